// ### hdl/timer_pkg.sv
// shared constants and state types for the timer prescaler and compare-flag block
package timer_pkg;

  // clock rate
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_FREQ_KHZ = 1000000 / CLK_PERIOD_NS;

  // data-space offsets of the registers
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h38;
  localparam logic [7:0] ADDR_GEN_CTRL = 8'h43;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h71;
  localparam logic [7:0] ADDR_CMP_A_LO = 8'h98;
  localparam logic [7:0] ADDR_CMP_A_HI = 8'h99;
  localparam logic [7:0] ADDR_CMP_B_LO = 8'h9A;
  localparam logic [7:0] ADDR_CMP_B_HI = 8'h9B;

  // io-space window
  localparam logic [7:0] IO_SPACE_SHIFT = 8'h20;
  localparam logic [7:0] IO_SPACE_LIMIT = 8'h40;
  localparam logic [7:0] EXT_SPACE_BASE = 8'h60;

  // field positions of the flag and mask registers
  localparam int BIT_CAPTURE = 5;
  localparam int BIT_COMPARE_B = 2;
  localparam int BIT_COMPARE_A = 1;
  localparam int BIT_OVERFLOW = 0;
  localparam logic [7:0] IRQ_BITS_MASK = 8'h27;

  // field positions of the general control register
  localparam int BIT_SYNC_MODE = 7;
  localparam int BIT_PRESCALER_RESET = 0;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // clock-select codes
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler taps: divisor and index
  localparam int PRESCALER_WIDTH = 10;
  localparam logic [9:0] TAP_MASK_8 = 10'h007;
  localparam logic [9:0] TAP_MASK_64 = 10'h03F;
  localparam logic [9:0] TAP_MASK_256 = 10'h0FF;
  localparam logic [9:0] TAP_MASK_1024 = 10'h3FF;
  localparam int TAP_8 = 0;
  localparam int TAP_64 = 1;
  localparam int TAP_256 = 2;
  localparam int TAP_1024 = 3;

  // waveform modes in which overflow is the wrap of the full count
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_CMP = 4'h4;
  localparam logic [3:0] WGM_CTC_CAP = 4'hC;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // top-level state
  typedef struct packed {
    logic [7:0] temp;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0] flags;
    logic [7:0] mask;
    logic sync_mode;
    logic psr;
    logic tick;
    logic block_match;
    logic match_a;
    logic match_b;
    logic [7:0] rdata;
  } top_state_t;

endpackage : timer_pkg

// ### hdl/clock_source_if.sv
// clock-source signals between the prescaler, pin synchroniser and selector
`timescale 1ns/10ps
interface clock_source_if;
  logic [3:0] tap;
  logic ext_rise;
  logic ext_fall;
  logic prescaler_clear;
  modport prescaler (input prescaler_clear, output tap);
  modport pin_sync (output ext_rise, output ext_fall);
  modport selector (output prescaler_clear, input tap, input ext_rise, input ext_fall);
endinterface : clock_source_if

// ### hdl/shared_prescaler.sv
// free-running ten-bit prescaler with four tap pulses
`timescale 1ns/10ps
module shared_prescaler (
  input wire logic ref_clk,
  input wire logic reset,
  clock_source_if.prescaler src
);

  typedef struct packed {
    logic [9:0] count;
  } presc_state_t;

  presc_state_t s_q;
  presc_state_t s_d;

  // free run, restarted by the shared clear
  always_comb begin
    s_d = s_q;
    if (src.prescaler_clear) begin
      s_d.count = 10'h000; // RQ14
    end else begin
      s_d.count = s_q.count + 10'h001; // RQ12
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // one-cycle pulse when the low bits wrap
  assign src.tap[timer_pkg::TAP_8] = (s_q.count & timer_pkg::TAP_MASK_8) == timer_pkg::TAP_MASK_8; // RQ11
  assign src.tap[timer_pkg::TAP_64] = (s_q.count & timer_pkg::TAP_MASK_64) == timer_pkg::TAP_MASK_64;
  assign src.tap[timer_pkg::TAP_256] = (s_q.count & timer_pkg::TAP_MASK_256) == timer_pkg::TAP_MASK_256;
  assign src.tap[timer_pkg::TAP_1024] = (s_q.count & timer_pkg::TAP_MASK_1024) == timer_pkg::TAP_MASK_1024;

endmodule : shared_prescaler

// ### hdl/count_pin_sync.sv
// external count pin synchroniser and edge detector
`timescale 1ns/10ps
module count_pin_sync (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic external_count_pin,
  clock_source_if.pin_sync src
);

  typedef struct packed {
    logic [2:0] sync;
    logic level;
    logic rise;
    logic fall;
  } pin_state_t;

  pin_state_t s_q;
  pin_state_t s_d;

  // three-stage sampling; a change counts once stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], external_count_pin}; // RQ15
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.level = s_q.sync[2];
      s_d.rise = s_q.sync[2] & ~s_q.level; // RQ16
      s_d.fall = ~s_q.sync[2] & s_q.level; // RQ16
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign src.ext_rise = s_q.rise;
  assign src.ext_fall = s_q.fall;

endmodule : count_pin_sync

// ### hdl/timer_prescaler_compare_flags.sv
// timer clock selection, compare registers, interrupt flags and mask
// Behaviour
// RQ1: compare both sixteen-bit values with the count on every timer tick
// RQ2: high byte writes go to a shared holding byte; low write updates both
// RQ3: enables at bits 5,2,1,0; request needs enable, global enable and flag
// RQ4: capture flag from capture event, or from reaching top when capture is top
// RQ5: compare flag set on the timer tick that ends a matching count
// RQ6: forced compare strobes drive the match outputs but never set flags
// RQ7: flags clear on vector acknowledge or on writing one to the bit
// RQ8: overflow flag on full wrap in normal and clear-on-match modes
// RQ9: low registers at offset or offset minus 0x20; extended from 0x60 data only
// RQ10: clock select 0x1 ticks every system clock
// RQ11: taps divide by 8, 64, 256 and 1024
// RQ12: one free-running prescaler shared by three timers
// RQ13: first prescaled tick comes within 1 to N+1 cycles of enabling
// RQ14: prescaler reset restarts the shared prescaler for every timer
// RQ15: count pin sampled every clock through a synchroniser chain
// RQ16: one tick per rising edge for 0x7, per falling edge for 0x6
// RQ17: counter moves a few cycles after the pin edge
// RQ18: the far side switches the external clock only while the pin is steady
// RQ19: the external clock stays well below half the system clock
// RQ20: external edges are never prescaled
// RQ21: clock select zero stops the timer
// RQ22: prescaler reset bit self-clears unless sync mode holds it
`timescale 1ns/10ps
module timer_prescaler_compare_flags (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] bus_addr,
  input wire logic bus_io_space,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  output logic [7:0] bus_rdata,
  input wire logic [2:0] clock_select_field,
  input wire logic [3:0] waveform_mode_field,
  input wire logic [15:0] timer_count,
  input wire logic count_written,
  input wire logic [15:0] capture_value,
  input wire logic capture_is_top,
  input wire logic capture_event,
  input wire logic mode_overflow_event,
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  input wire logic ack_capture,
  input wire logic ack_compare_a,
  input wire logic ack_compare_b,
  input wire logic ack_overflow,
  output logic timer_tick,
  output logic wave_match_a,
  output logic wave_match_b,
  output logic [3:0] shared_taps,
  output logic prescaler_clear,
  output logic [15:0] compare_a_value,
  output logic [15:0] compare_b_value,
  output logic irq_capture,
  output logic irq_compare_a,
  output logic irq_compare_b,
  output logic irq_overflow
);

  timer_pkg::top_state_t s_q;
  timer_pkg::top_state_t s_d;

  clock_source_if src ();

  // map a bus address onto the data-space offset
  function automatic logic [7:0] data_offset(input logic [7:0] addr, input logic io);
    if (io) begin
      data_offset = addr + timer_pkg::IO_SPACE_SHIFT; // RQ9
    end else begin
      data_offset = addr;
    end
  endfunction : data_offset

  // io-space addressing only reaches the low window
  function automatic logic access_legal(input logic [7:0] addr, input logic io);
    access_legal = !io || (addr < timer_pkg::IO_SPACE_LIMIT); // RQ9
  endfunction : access_legal

  // an offset in the extended space refuses io-space access
  function automatic logic is_extended(input logic [7:0] offset);
    is_extended = offset >= timer_pkg::EXT_SPACE_BASE;
  endfunction : is_extended

  // update a set-wins flag with separate clear terms
  function automatic logic flag_next(input logic cur, input logic set, input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  shared_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .reset(reset),
    .src(src.prescaler)
  );

  count_pin_sync u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .external_count_pin(external_count_pin),
    .src(src.pin_sync)
  );

  // shared prescaler is held in reset while the reset bit stands
  assign src.prescaler_clear = s_q.psr; // RQ14

  logic [7:0] offset;
  logic legal;
  logic wr_hit;
  logic rd_hit;
  logic tick_now;
  logic hit_a;
  logic hit_b;
  logic set_cap;
  logic set_ovf;
  logic wrap_mode;
  logic [7:0] w1c;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;

  // address decode for both access spaces
  always_comb begin
    offset = data_offset(bus_addr, bus_io_space);
    legal = access_legal(bus_addr, bus_io_space) && !(bus_io_space && is_extended(offset)); // RQ9
    wr_hit = bus_wr && legal;
    rd_hit = bus_rd && legal;
  end

  // timer clock selection
  always_comb begin
    tick_now = 1'b0;
    unique case (clock_select_field)
      timer_pkg::CS_STOPPED: tick_now = 1'b0; // RQ21
      timer_pkg::CS_DIRECT: tick_now = 1'b1; // RQ10
      timer_pkg::CS_DIV8: tick_now = src.tap[timer_pkg::TAP_8]; // RQ11 RQ13
      timer_pkg::CS_DIV64: tick_now = src.tap[timer_pkg::TAP_64]; // RQ11
      timer_pkg::CS_DIV256: tick_now = src.tap[timer_pkg::TAP_256]; // RQ11
      timer_pkg::CS_DIV1024: tick_now = src.tap[timer_pkg::TAP_1024]; // RQ11
      timer_pkg::CS_EXT_FALL: tick_now = src.ext_fall; // RQ16 RQ20
      timer_pkg::CS_EXT_RISE: tick_now = src.ext_rise; // RQ16 RQ20 RQ17
    endcase
  end

  // events seen on the current timer tick
  always_comb begin
    wrap_mode = (waveform_mode_field == timer_pkg::WGM_NORMAL) ||
                (waveform_mode_field == timer_pkg::WGM_CTC_CMP) ||
                (waveform_mode_field == timer_pkg::WGM_CTC_CAP);
    hit_a = s_q.tick && !s_q.block_match && (timer_count == s_q.cmp_a); // RQ1 RQ5
    hit_b = s_q.tick && !s_q.block_match && (timer_count == s_q.cmp_b); // RQ1 RQ5
    if (capture_is_top) begin
      set_cap = s_q.tick && (timer_count == capture_value); // RQ4
    end else begin
      set_cap = capture_event; // RQ4
    end
    if (wrap_mode) begin
      set_ovf = s_q.tick && (timer_count == timer_pkg::COUNT_MAX); // RQ8
    end else begin
      set_ovf = mode_overflow_event; // RQ8
    end
  end

  // flag set and clear vectors
  always_comb begin
    set_bits = 8'h00;
    set_bits[timer_pkg::BIT_CAPTURE] = set_cap;
    set_bits[timer_pkg::BIT_COMPARE_B] = hit_b; // RQ6
    set_bits[timer_pkg::BIT_COMPARE_A] = hit_a; // RQ6
    set_bits[timer_pkg::BIT_OVERFLOW] = set_ovf;
    w1c = 8'h00;
    if (wr_hit && offset == timer_pkg::ADDR_IRQ_FLAGS) begin
      w1c = bus_wdata & timer_pkg::IRQ_BITS_MASK; // RQ7
    end
    clr_bits = w1c;
    clr_bits[timer_pkg::BIT_CAPTURE] = w1c[timer_pkg::BIT_CAPTURE] | ack_capture; // RQ7
    clr_bits[timer_pkg::BIT_COMPARE_B] = w1c[timer_pkg::BIT_COMPARE_B] | ack_compare_b; // RQ7
    clr_bits[timer_pkg::BIT_COMPARE_A] = w1c[timer_pkg::BIT_COMPARE_A] | ack_compare_a; // RQ7
    clr_bits[timer_pkg::BIT_OVERFLOW] = w1c[timer_pkg::BIT_OVERFLOW] | ack_overflow; // RQ7
  end

  // next state
  always_comb begin
    s_d = s_q;
    s_d.tick = tick_now;
    // a count write removes the compare on the following tick
    if (count_written) begin
      s_d.block_match = 1'b1;
    end else if (s_q.tick) begin
      s_d.block_match = 1'b0;
    end
    // waveform match: real match or forced strobe
    s_d.match_a = hit_a | force_compare_a; // RQ1 RQ6
    s_d.match_b = hit_b | force_compare_b; // RQ1 RQ6
    // flags, set wins over clear
    for (int i = 0; i < 8; i++) begin
      s_d.flags[i] = flag_next(s_q.flags[i], set_bits[i], clr_bits[i]) & timer_pkg::IRQ_BITS_MASK[i];
    end
    // prescaler reset bit self-clears unless sync mode holds it
    if (s_q.psr && !s_q.sync_mode) begin
      s_d.psr = 1'b0; // RQ22
    end
    if (wr_hit) begin
      unique case (offset)
        timer_pkg::ADDR_IRQ_MASK: begin
          s_d.mask = bus_wdata & timer_pkg::IRQ_BITS_MASK; // RQ3
        end
        timer_pkg::ADDR_GEN_CTRL: begin
          s_d.sync_mode = bus_wdata[timer_pkg::BIT_SYNC_MODE];
          s_d.psr = bus_wdata[timer_pkg::BIT_PRESCALER_RESET]; // RQ22
        end
        timer_pkg::ADDR_CMP_A_HI, timer_pkg::ADDR_CMP_B_HI: begin
          s_d.temp = bus_wdata; // RQ2
        end
        timer_pkg::ADDR_CMP_A_LO: begin
          s_d.cmp_a = {s_q.temp, bus_wdata}; // RQ2
        end
        timer_pkg::ADDR_CMP_B_LO: begin
          s_d.cmp_b = {s_q.temp, bus_wdata}; // RQ2
        end
        default: begin
        end
      endcase
    end
    // read data, unmapped reads as zero
    if (rd_hit) begin
      unique case (offset)
        timer_pkg::ADDR_IRQ_FLAGS: s_d.rdata = s_q.flags;
        timer_pkg::ADDR_IRQ_MASK: s_d.rdata = s_q.mask;
        timer_pkg::ADDR_GEN_CTRL: begin
          s_d.rdata = 8'h00;
          s_d.rdata[timer_pkg::BIT_SYNC_MODE] = s_q.sync_mode;
          s_d.rdata[timer_pkg::BIT_PRESCALER_RESET] = s_q.psr;
        end
        timer_pkg::ADDR_CMP_A_LO: s_d.rdata = s_q.cmp_a[7:0];
        timer_pkg::ADDR_CMP_A_HI: s_d.rdata = s_q.cmp_a[15:8];
        timer_pkg::ADDR_CMP_B_LO: s_d.rdata = s_q.cmp_b[7:0];
        timer_pkg::ADDR_CMP_B_HI: s_d.rdata = s_q.cmp_b[15:8];
        default: s_d.rdata = timer_pkg::RESET_BYTE;
      endcase
    end else begin
      s_d.rdata = timer_pkg::RESET_BYTE;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q.temp <= timer_pkg::RESET_BYTE;
      s_q.cmp_a <= timer_pkg::RESET_WORD;
      s_q.cmp_b <= timer_pkg::RESET_WORD;
      s_q.flags <= timer_pkg::RESET_BYTE;
      s_q.mask <= timer_pkg::RESET_BYTE;
      s_q.sync_mode <= 1'b0;
      s_q.psr <= 1'b0;
      s_q.tick <= 1'b0;
      s_q.block_match <= 1'b0;
      s_q.match_a <= 1'b0;
      s_q.match_b <= 1'b0;
      s_q.rdata <= timer_pkg::RESET_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign bus_rdata = s_q.rdata;
  assign timer_tick = s_q.tick;
  assign wave_match_a = s_q.match_a;
  assign wave_match_b = s_q.match_b;
  assign shared_taps = src.tap; // RQ12
  assign prescaler_clear = s_q.psr;
  assign compare_a_value = s_q.cmp_a;
  assign compare_b_value = s_q.cmp_b;

  // interrupt requests need enable, global enable and flag
  assign irq_capture = global_irq_enable & s_q.mask[timer_pkg::BIT_CAPTURE] & s_q.flags[timer_pkg::BIT_CAPTURE]; // RQ3
  assign irq_compare_a = global_irq_enable & s_q.mask[timer_pkg::BIT_COMPARE_A] &
                         s_q.flags[timer_pkg::BIT_COMPARE_A]; // RQ3
  assign irq_compare_b = global_irq_enable & s_q.mask[timer_pkg::BIT_COMPARE_B] &
                         s_q.flags[timer_pkg::BIT_COMPARE_B]; // RQ3
  assign irq_overflow = global_irq_enable & s_q.mask[timer_pkg::BIT_OVERFLOW] &
                        s_q.flags[timer_pkg::BIT_OVERFLOW]; // RQ3

endmodule : timer_prescaler_compare_flags

// ### verif/timer_flags_chk.sv
// concurrent checks on the ports of the timer prescaler and flag block
`timescale 1ns/10ps
module timer_flags_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] bus_addr,
  input wire logic bus_io_space,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [2:0] clock_select_field,
  input wire logic external_count_pin,
  input wire logic global_irq_enable,
  input wire logic force_compare_a,
  input wire logic force_compare_b,
  input wire logic timer_tick,
  input wire logic wave_match_a,
  input wire logic wave_match_b,
  input wire logic [3:0] shared_taps,
  input wire logic prescaler_clear,
  input wire logic irq_capture,
  input wire logic irq_compare_a,
  input wire logic irq_compare_b,
  input wire logic irq_overflow
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // bus read data and address window
  a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_io_refused: assert property (bus_rd && bus_io_space && bus_addr >= 8'h40 |=> bus_rdata == 8'h00)
    else $error("io read above window returned data");
  // clock selection
  a_direct_tick: assert property (clock_select_field == 3'h1 |=> timer_tick)
    else $error("direct select missed a tick");
  a_stop_tick: assert property (clock_select_field == 3'h0 |=> !timer_tick)
    else $error("stopped timer ticked");
  a_div8_tick: assert property (clock_select_field == 3'h2 |=> timer_tick == $past(shared_taps[0]))
    else $error("divide by 8 tick not following tap");
  a_tap_spacing: assert property (shared_taps[0] |=> !shared_taps[0] [*7])
    else $error("divide by 8 taps too close");
  a_tap_nesting: assert property ((!shared_taps[1] || shared_taps[0]) && (!shared_taps[2] || shared_taps[1])
    && (!shared_taps[3] || shared_taps[2]))
    else $error("slow tap without faster tap");
  a_psr_restart: assert property ($fell(prescaler_clear) |-> !shared_taps[0] [*5])
    else $error("tap too soon after prescaler restart");
  a_ext_rise: assert property (clock_select_field == 3'h7 && $rose(external_count_pin)
    |-> ##[2:7] timer_tick)
    else $error("pin rise gave no tick");
  // interrupt gating and forced compare
  a_irq_gate: assert property (!global_irq_enable |-> !(irq_capture || irq_compare_a || irq_compare_b
    || irq_overflow))
    else $error("request without global enable");
  a_force_a: assert property (force_compare_a |=> wave_match_a)
    else $error("forced compare a gave no match");
  a_force_b: assert property (force_compare_b |=> wave_match_b)
    else $error("forced compare b gave no match");
endmodule : timer_flags_chk

bind timer_prescaler_compare_flags timer_flags_chk i_chk (.ref_clk, .reset, .bus_addr, .bus_io_space, .bus_rd,
  .bus_rdata, .clock_select_field, .external_count_pin, .global_irq_enable, .force_compare_a, .force_compare_b,
  .timer_tick, .wave_match_a, .wave_match_b, .shared_taps, .prescaler_clear, .irq_capture, .irq_compare_a,
  .irq_compare_b, .irq_overflow);

// ### verif/count_clock_source.sv
// external count clock source driving the count pin
`timescale 1ns/10ps
module count_clock_source #(
  parameter int HALF = 4
) (
  input wire logic ref_clk,
  input wire logic run,
  output logic external_count_pin
);
  int cnt = 0;
  initial external_count_pin = 1'b0;
  // toggle each half period while running, stand still between bursts
  always @(negedge ref_clk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        external_count_pin <= !external_count_pin;
      end
    end
  end
endmodule : count_clock_source

// ### verif/timer_prescaler_compare_flags_tb.sv
// testbench for the timer prescaler, compare and flag block
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module timer_prescaler_compare_flags_tb;
  logic ref_clk = 1'b0, reset = 1'b1, bus_io_space = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
  logic [2:0] cs = 3'h0;
  logic [3:0] wave_mode = 4'h0, acks = 4'h0, irq, shared_taps;
  logic [15:0] timer_count = 16'h0000, capture_value = 16'h0000, cmp_a, cmp_b;
  logic capture_is_top = 1'b0, capture_event = 1'b0, ovf_ev = 1'b0, force_a = 1'b0, force_b = 1'b0;
  logic gie = 1'b0, run = 1'b0, pin, timer_tick, prescaler_clear, cw = 1'b0, wm_a, wm_b;
  int err_total = 0, tests_run = 0, ticks = 0, taps = 0, t0, p0;
  logic [7:0] regs[6] = '{8'h38, 8'h71, 8'h98, 8'h99, 8'h9A, 8'h9B};
  int exp_t[6] = '{0, 2048, 256, 32, 8, 2};

  timer_prescaler_compare_flags i_dut (.ref_clk, .reset, .bus_addr, .bus_io_space, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .clock_select_field(cs), .waveform_mode_field(wave_mode), .timer_count,
    .count_written(cw), .capture_value, .capture_is_top, .capture_event, .mode_overflow_event(ovf_ev),
    .force_compare_a(force_a), .force_compare_b(force_b), .external_count_pin(pin), .global_irq_enable(gie),
    .ack_capture(acks[3]), .ack_compare_a(acks[1]), .ack_compare_b(acks[2]), .ack_overflow(acks[0]),
    .timer_tick, .wave_match_a(wm_a), .wave_match_b(wm_b), .shared_taps, .prescaler_clear,
    .compare_a_value(cmp_a), .compare_b_value(cmp_b), .irq_capture(irq[3]), .irq_compare_a(irq[1]),
    .irq_compare_b(irq[2]), .irq_overflow(irq[0]));
  count_clock_source i_src (.ref_clk, .run, .external_count_pin(pin));

  // clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // tick and tap counters
  always @(posedge ref_clk) begin
    ticks <= ticks + timer_tick;
    taps <= taps + shared_taps[0];
  end

  // one bus access, read data taken after the read edge
  task automatic acc(input logic [7:0] a, input logic io, input logic [7:0] v, input logic r);
    @(negedge ref_clk);
    bus_addr = a;
    bus_io_space = io;
    bus_wdata = v;
    bus_wr = !r;
    bus_rd = r;
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  endtask : acc

  task automatic rchk(input logic [7:0] a, input logic io, input logic [7:0] e);
    acc(a, io, 8'h00, 1'b1);
    `CHK(bus_rdata, e)
  endtask : rchk

  // one cycle of count value and event strobes
  task automatic ev(input logic [15:0] c, input logic [3:0] e);
    @(negedge ref_clk);
    timer_count = c;
    {force_b, force_a, ovf_ev, capture_event} = e;
    @(negedge ref_clk);
    timer_count = 16'h0000;
    {force_b, force_a, ovf_ev, capture_event} = 4'h0;
  endtask : ev

  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // hang guard
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    summarize();
  end

  // main sequence
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    foreach (regs[i]) rchk(regs[i], 1'b0, 8'h00);
    acc(8'h99, 1'b0, 8'hAB, 1'b0);
    acc(8'h98, 1'b0, 8'hCD, 1'b0);
    acc(8'h9B, 1'b0, 8'h12, 1'b0);
    `CHK(cmp_b, 16'h0000)
    acc(8'h9A, 1'b0, 8'h34, 1'b0);
    `CHK({cmp_a, cmp_b}, 32'hABCD1234)
    acc(8'h99, 1'b0, 8'h56, 1'b0);
    acc(8'h9A, 1'b0, 8'h78, 1'b0);
    `CHK({cmp_a, cmp_b}, 32'hABCD5678)
    rchk(8'h9B, 1'b0, 8'h56);
    acc(8'h51, 1'b1, 8'hFF, 1'b0);
    rchk(8'h71, 1'b0, 8'h00);
    acc(8'h71, 1'b0, 8'hFF, 1'b0);
    rchk(8'h71, 1'b0, 8'h27);
    rchk(8'h51, 1'b1, 8'h00);
    // flags with a tick on every clock
    gie = 1'b1;
    cs = 3'h1;
    ev(16'hABCD, 4'h0);
    `CHK({wm_b, wm_a}, 2'b01)
    rchk(8'h18, 1'b1, 8'h02);
    `CHK(irq, 4'h2)
    ev(16'h5678, 4'h0);
    `CHK({wm_b, wm_a}, 2'b10)
    ev(16'hFFFF, 4'h0);
    ev(16'h0000, 4'h1);
    rchk(8'h38, 1'b0, 8'h27);
    `CHK(irq, 4'hF)
    gie = 1'b0;
    @(negedge ref_clk);
    `CHK(irq, 4'h0)
    acc(8'h18, 1'b1, 8'h06, 1'b0);
    rchk(8'h38, 1'b0, 8'h21);
    acks = 4'h9;
    @(negedge ref_clk);
    acks = 4'h0;
    rchk(8'h38, 1'b0, 8'h00);
    // a count write removes the compare on the next tick
    cw = 1'b1;
    @(negedge ref_clk);
    cw = 1'b0;
    timer_count = 16'hABCD;
    @(negedge ref_clk);
    timer_count = 16'h0000;
    `CHK({wm_b, wm_a}, 2'b00)
    rchk(8'h38, 1'b0, 8'h00);
    ev(16'h0000, 4'hC);
    wave_mode = 4'h1;
    capture_is_top = 1'b1;
    capture_value = 16'h0100;
    ev(16'hFFFF, 4'h0);
    rchk(8'h38, 1'b0, 8'h00);
    ev(16'h0000, 4'h3);
    rchk(8'h38, 1'b0, 8'h01);
    ev(16'h0100, 4'h0);
    rchk(8'h38, 1'b0, 8'h21);
    // every internal clock select over a fixed window
    for (int i = 0; i < 6; i++) begin
      cs = 3'(i);
      repeat (2) @(negedge ref_clk);
      t0 = ticks;
      p0 = taps;
      repeat (2048) @(negedge ref_clk);
      `CHK(ticks - t0, exp_t[i])
      `CHK(taps - p0, 256)
    end
    // prescaler restart, single and held in sync mode
    cs = 3'h0;
    acc(8'h23, 1'b1, 8'h01, 1'b0);
    `CHK(prescaler_clear, 1'b1)
    @(negedge ref_clk);
    `CHK(prescaler_clear, 1'b0)
    acc(8'h43, 1'b0, 8'h81, 1'b0);
    @(negedge ref_clk);
    p0 = taps;
    repeat (20) @(negedge ref_clk);
    `CHK(prescaler_clear, 1'b1)
    `CHK(taps - p0, 0)
    acc(8'h43, 1'b0, 8'h00, 1'b0);
    @(negedge ref_clk);
    `CHK(prescaler_clear, 1'b0)
    cs = 3'h2;
    t0 = ticks;
    repeat (10) @(negedge ref_clk);
    `CHK((ticks - t0) inside {1, 2}, 1'b1)
    // external pin, rising then falling edges, pin steady when switching
    for (int i = 0; i < 2; i++) begin
      cs = i ? 3'h6 : 3'h7;
      @(negedge ref_clk);
      t0 = ticks;
      run = 1'b1;
      repeat (64) @(negedge ref_clk);
      run = 1'b0;
      repeat (10) @(negedge ref_clk);
      `CHK(ticks - t0, 8)
    end
    summarize();
  end
endmodule : timer_prescaler_compare_flags_tb
